// [hdl/csp_pkg.sv]
// package: register map, field layout and constants for the clock setup block
package csp_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_OSC_CTRL   = 8'h20;
    localparam logic [7:0] OFF_OSC_FREQ   = 8'h24;
    localparam logic [7:0] OFF_SYN_A      = 8'h28;
    localparam logic [7:0] OFF_SYN_B      = 8'h2C;
    localparam logic [7:0] OFF_BUS_CLK    = 8'h30;
    localparam logic [7:0] OFF_STATUS     = 8'h68;
    localparam logic [7:0] OFF_IRQ_EN     = 8'h6C;
    localparam logic [7:0] OFF_CP_CFG     = 8'h80;
    // reset values
    localparam logic [31:0] SYN_RESET     = 32'h0000_3F00;
    // oscillator control fields
    localparam int OSC_EN_BIT   = 0;
    localparam int OSC_CNT_LSB  = 8;
    localparam int OSC_CNT_W    = 8;
    localparam int OSC_MULT_SH  = 3;    // start-up is 8 x count
    // frequency register fields
    localparam int FRQ_CNT_W    = 16;
    localparam int FRQ_VALID    = 16;
    localparam int FRQ_WINDOW   = 16;
    // synthesizer fields
    localparam int SYN_DIV_LSB  = 0;
    localparam int SYN_DIV_W    = 8;
    localparam int SYN_CNT_LSB  = 8;
    localparam int SYN_CNT_W    = 6;
    localparam int SYN_RNG_LSB  = 14;
    localparam int SYN_RNG_W    = 2;
    localparam int SYN_MUL_LSB  = 16;
    localparam int SYN_MUL_W    = 11;
    localparam int SYN_USB_LSB  = 28;
    localparam int SYN_USB_W    = 2;
    localparam int SYN_SRC_BIT  = 29;
    localparam int SYN_CFG_W    = 30;
    // bus clock fields
    localparam int BCK_SRC_LSB  = 0;
    localparam int BCK_SRC_W    = 2;
    localparam int BCK_PRE_LSB  = 2;
    localparam int BCK_PRE_W    = 3;
    localparam int BCK_RAT_LSB  = 8;
    localparam int BCK_RAT_W    = 2;
    // status bit positions
    localparam int ST_OSC       = 0;
    localparam int ST_LOCK_A    = 1;
    localparam int ST_LOCK_B    = 2;
    localparam int ST_BUS_RDY   = 3;
    localparam int ST_W         = 4;
    // clock source codes
    localparam logic [1:0] SRC_SLOW = 2'h0;
    localparam logic [1:0] SRC_MAIN = 2'h1;
    localparam logic [1:0] SRC_SYNA = 2'h2;
    localparam logic [1:0] SRC_SYNB = 2'h3;
    // settle cycles of the new clock after a bus clock change
    localparam int BCK_SETTLE   = 64;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// [hdl/csp_clock_setup.sv]
// clock source, synthesizer setup and master clock selection logic
`timescale 1ns/1ps
// Functional notes
// R1: oscillator enable starts start-up; stable flag after 8 x count slow ticks
// R2: each status flag drives interrupt when its enable bit is set
// R3: main clock cycles counted over sixteen slow ticks, then valid flag set
// R4: software sets charge pump select before writing a synthesizer config
// R5: software always writes bit 29 of synthesizer A config as one
// R6: input divider takes 0..255, divides by value; zero turns it off
// R7: multiplier 0..2047; zero disables, else output is input times value+1
// R8: lock flag sets after programmed lock count of slow ticks
// R9: source, multiplier or divider change clears lock flag at once
// R10: software waits for lock before using a synthesizer output
// R11: range field selects synthesizer output frequency range
// R12: usb divider divides synthesizer B output by 1, 2 or 4
// R13: bus clock source picks slow, main or synth clocks; resets to slow
// R14: power divider divides by 1 to 64; zero means divide by one
// R15: ratio 0,1,2 makes master clock the processor clock over 1, 2, 4
// R16: source or divider change clears ready until new clocks settle
// R17: software never changes source and divider in one write
// R18: to main or slow clock, write source first, then divider
// R19: ready stays low while the feeding synthesizer is unlocked
// R20: unlocked A falls back to slow clock, unlocked B to main clock
// R21: all synthesizer fields are taken together in one write
// R22: software waits for ready after any change before using clocks
// R23: lock counter loads count, decrements per slow tick, flags at zero
// R24: master clock changes are applied without runt pulses
module csp_clock_setup
    import csp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        slow_tick,
    input  wire logic        main_tick,
    input  wire logic        syn_a_tick,
    input  wire logic        syn_b_tick,
    output logic             osc_enable,
    output logic [SYN_DIV_W-1:0] syn_a_div,
    output logic [SYN_MUL_W-1:0] syn_a_mul,
    output logic [SYN_RNG_W-1:0] syn_a_range,
    output logic             syn_a_on,
    output logic [SYN_DIV_W-1:0] syn_b_div,
    output logic [SYN_MUL_W-1:0] syn_b_mul,
    output logic [SYN_RNG_W-1:0] syn_b_range,
    output logic             syn_b_on,
    output logic [SYN_USB_W-1:0] usb_div_log2,
    output logic [BCK_SRC_W-1:0] bus_src_active,
    output logic [BCK_PRE_W-1:0] bus_pre_active,
    output logic [BCK_RAT_W-1:0] core_bus_ratio,
    output logic             clock_irq
);
    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic       wr_pend_q, wr_pend_d;
    logic [7:0] addr_q, addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic       wr_now;
    logic [31:0] rd_mux;

    logic                 osc_en_q, osc_en_d;
    logic [OSC_CNT_W-1:0] osc_cnt_q, osc_cnt_d;
    logic [SYN_CFG_W-1:0] syn_a_q, syn_a_d, syn_b_q, syn_b_d;
    logic [BCK_SRC_W-1:0] bsrc_q, bsrc_d;
    logic [BCK_PRE_W-1:0] bpre_q, bpre_d;
    logic [BCK_RAT_W-1:0] brat_q, brat_d;
    logic [ST_W-1:0]      irq_en_q, irq_en_d;
    logic [1:0]           cp_q, cp_d;
    logic [ST_W-1:0]      status;
    logic [FRQ_CNT_W-1:0] frq_q;
    logic                 frq_valid_q;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;
    assign wr_now    = wr_pend_q;

    always_comb begin
        rd_mux = '0;
        case (haddr[7:0])
            OFF_OSC_CTRL: begin
                rd_mux[OSC_EN_BIT] = osc_en_q;
                rd_mux[OSC_CNT_LSB +: OSC_CNT_W] = osc_cnt_q;
            end
            OFF_OSC_FREQ: begin
                rd_mux[FRQ_CNT_W-1:0] = frq_q;
                rd_mux[FRQ_VALID] = frq_valid_q;
            end
            OFF_SYN_A:   rd_mux[SYN_CFG_W-1:0] = syn_a_q;
            OFF_SYN_B:   rd_mux[SYN_CFG_W-1:0] = syn_b_q;
            OFF_BUS_CLK: begin
                rd_mux[BCK_SRC_LSB +: BCK_SRC_W] = bsrc_q;
                rd_mux[BCK_PRE_LSB +: BCK_PRE_W] = bpre_q;
                rd_mux[BCK_RAT_LSB +: BCK_RAT_W] = brat_q;
            end
            OFF_STATUS:  rd_mux[ST_W-1:0] = status;
            OFF_IRQ_EN:  rd_mux[ST_W-1:0] = irq_en_q;
            OFF_CP_CFG:  rd_mux[1:0] = cp_q;
            default:     rd_mux = '0;
        endcase
    end

    always_comb begin
        wr_pend_d = 1'b0;
        addr_d    = addr_q;
        rdata_d   = rdata_q;
        if (hsel && hready && htrans == HTRANS_NONSEQ) begin
            wr_pend_d = hwrite;
            addr_d    = haddr[7:0];
            if (!hwrite)
                rdata_d = rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic syn_a_wr, syn_b_wr, bck_wr;
    logic syn_a_chg, syn_b_chg, bck_chg;

    assign syn_a_wr = wr_now && addr_q == OFF_SYN_A;
    assign syn_b_wr = wr_now && addr_q == OFF_SYN_B;
    assign bck_wr   = wr_now && addr_q == OFF_BUS_CLK;
    // any rewrite restarts locking; key fields changing matter too
    assign syn_a_chg = syn_a_wr;                                  // [R9]
    assign syn_b_chg = syn_b_wr;                                  // [R9]
    assign bck_chg   = bck_wr &&
        (hwdata[BCK_SRC_LSB +: BCK_SRC_W] != bsrc_q ||
         hwdata[BCK_PRE_LSB +: BCK_PRE_W] != bpre_q);             // [R16]

    always_comb begin
        osc_en_d  = osc_en_q;
        osc_cnt_d = osc_cnt_q;
        syn_a_d   = syn_a_q;
        syn_b_d   = syn_b_q;
        bsrc_d    = bsrc_q;
        bpre_d    = bpre_q;
        brat_d    = brat_q;
        irq_en_d  = irq_en_q;
        cp_d      = cp_q;
        if (wr_now) begin
            case (addr_q)
                OFF_OSC_CTRL: begin
                    osc_en_d  = hwdata[OSC_EN_BIT];                // [R1]
                    osc_cnt_d = hwdata[OSC_CNT_LSB +: OSC_CNT_W];
                end
                OFF_SYN_A: syn_a_d = hwdata[SYN_CFG_W-1:0];        // [R21]
                OFF_SYN_B: syn_b_d = hwdata[SYN_CFG_W-1:0];        // [R21]
                OFF_BUS_CLK: begin
                    bsrc_d = hwdata[BCK_SRC_LSB +: BCK_SRC_W];     // [R13]
                    bpre_d = hwdata[BCK_PRE_LSB +: BCK_PRE_W];     // [R14]
                    brat_d = hwdata[BCK_RAT_LSB +: BCK_RAT_W];     // [R15]
                end
                OFF_IRQ_EN: irq_en_d = hwdata[ST_W-1:0];           // [R2]
                OFF_CP_CFG: cp_d = hwdata[1:0];                    // [R4]
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // oscillator start-up and frequency measurement
    // ----------------------------------------------------------------
    localparam int OSC_TMR_W = OSC_CNT_W + OSC_MULT_SH;
    logic [OSC_TMR_W-1:0] osc_tmr_q, osc_tmr_d;
    logic                 osc_ok_q, osc_ok_d;
    logic [4:0]           win_q, win_d;
    logic [FRQ_CNT_W-1:0] mcnt_q, mcnt_d, frq_d;
    logic                 frq_valid_d;

    always_comb begin
        osc_tmr_d = osc_tmr_q;
        osc_ok_d  = osc_ok_q;
        if (wr_now && addr_q == OFF_OSC_CTRL) begin
            osc_ok_d  = 1'b0;
            osc_tmr_d = {hwdata[OSC_CNT_LSB +: OSC_CNT_W],
                         OSC_MULT_SH'(0)};                         // [R1]
        end else if (!osc_en_q) begin
            osc_ok_d = 1'b0;
        end else if (!osc_ok_q && slow_tick) begin
            if (osc_tmr_q <= OSC_TMR_W'(1))
                osc_ok_d = 1'b1;                                   // [R1]
            if (osc_tmr_q != '0)
                osc_tmr_d = osc_tmr_q - 1'b1;
        end
    end

    // window counts main ticks across sixteen slow ticks once stable
    always_comb begin
        win_d       = win_q;
        mcnt_d      = mcnt_q;
        frq_d       = frq_q;
        frq_valid_d = frq_valid_q;
        if (!osc_ok_q) begin
            win_d       = '0;
            mcnt_d      = '0;
            frq_valid_d = 1'b0;
        end else if (!frq_valid_q) begin
            if (main_tick && win_q != '0)
                mcnt_d = mcnt_q + 1'b1;                            // [R3]
            if (slow_tick) begin
                if (win_q == 5'(FRQ_WINDOW)) begin
                    frq_d       = mcnt_d;                          // [R3]
                    frq_valid_d = 1'b1;                            // [R3]
                end else begin
                    win_d = win_q + 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // synthesizer lock counters, one per synthesizer
    // ----------------------------------------------------------------
    logic [1:0]           lock_q, lock_d;
    logic [SYN_CNT_W-1:0] lcnt_q [2];
    logic [SYN_CNT_W-1:0] lcnt_d [2];
    logic [SYN_CFG_W-1:0] syn_cfg [2];
    logic [1:0]           syn_chg;

    assign syn_cfg[0] = syn_a_q;
    assign syn_cfg[1] = syn_b_q;
    assign syn_chg    = {syn_b_chg, syn_a_chg};

    for (genvar i = 0; i < 2; i++) begin : g_lock
        always_comb begin
            lcnt_d[i] = lcnt_q[i];
            lock_d[i] = lock_q[i];
            if (syn_chg[i]) begin
                lock_d[i] = 1'b0;                                  // [R9]
                lcnt_d[i] = hwdata[SYN_CNT_LSB +: SYN_CNT_W];      // [R23]
            end else if (syn_cfg[i][SYN_MUL_LSB +: SYN_MUL_W] == '0 ||
                         syn_cfg[i][SYN_DIV_LSB +: SYN_DIV_W] == '0) begin
                lock_d[i] = 1'b0;                                  // [R7]
            end else if (!lock_q[i] && slow_tick) begin
                if (lcnt_q[i] <= SYN_CNT_W'(1))
                    lock_d[i] = 1'b1;                              // [R8]
                if (lcnt_q[i] != '0)
                    lcnt_d[i] = lcnt_q[i] - 1'b1;                  // [R23]
            end
        end
        always_ff @(posedge clk) begin
            if (!rstn)
                lcnt_q[i] <= '0;
            else
                lcnt_q[i] <= lcnt_d[i];
        end
    end

    // analog controls: divider off at zero, synth off at zero multiplier
    assign syn_a_div   = syn_a_q[SYN_DIV_LSB +: SYN_DIV_W];        // [R6]
    assign syn_a_mul   = syn_a_q[SYN_MUL_LSB +: SYN_MUL_W];        // [R7]
    assign syn_a_range = syn_a_q[SYN_RNG_LSB +: SYN_RNG_W];        // [R11]
    assign syn_a_on    = syn_a_mul != '0 && syn_a_div != '0;       // [R6]
    assign syn_b_div   = syn_b_q[SYN_DIV_LSB +: SYN_DIV_W];        // [R6]
    assign syn_b_mul   = syn_b_q[SYN_MUL_LSB +: SYN_MUL_W];        // [R7]
    assign syn_b_range = syn_b_q[SYN_RNG_LSB +: SYN_RNG_W];        // [R11]
    assign syn_b_on    = syn_b_mul != '0 && syn_b_div != '0;       // [R6]
    assign usb_div_log2 = syn_b_q[SYN_USB_LSB +: SYN_USB_W];       // [R12]

    // ----------------------------------------------------------------
    // master clock selection and ready
    // ----------------------------------------------------------------
    // effective source with fallback while the chosen synth is unlocked
    logic [BCK_SRC_W-1:0] eff_src;
    logic                 src_locked;
    logic                 sel_tick;

    always_comb begin
        eff_src    = bsrc_q;
        src_locked = 1'b1;
        case (bsrc_q)
            SRC_SYNA: begin
                src_locked = lock_q[0];                            // [R19]
                if (!lock_q[0])
                    eff_src = SRC_SLOW;                            // [R20]
            end
            SRC_SYNB: begin
                src_locked = lock_q[1];                            // [R19]
                if (!lock_q[1])
                    eff_src = SRC_MAIN;                            // [R20]
            end
            default: ;
        endcase
        case (bus_src_active)
            SRC_SLOW: sel_tick = slow_tick;
            SRC_MAIN: sel_tick = main_tick;
            SRC_SYNA: sel_tick = syn_a_tick;
            default:  sel_tick = syn_b_tick;
        endcase
    end

    // switch only on a slow tick boundary so the output never runts
    logic [BCK_SRC_W-1:0] act_src_q, act_src_d;
    logic [BCK_PRE_W-1:0] act_pre_q, act_pre_d;
    logic [6:0]           settle_q, settle_d;
    logic                 rdy_q, rdy_d;

    always_comb begin
        act_src_d = act_src_q;
        act_pre_d = act_pre_q;
        settle_d  = settle_q;
        rdy_d     = rdy_q;
        if (bck_chg) begin
            rdy_d    = 1'b0;                                       // [R16]
            settle_d = 7'(BCK_SETTLE);
        end else if (act_src_q != eff_src || act_pre_q != bpre_q) begin
            rdy_d = 1'b0;
            if (slow_tick) begin
                act_src_d = eff_src;                               // [R24]
                act_pre_d = bpre_q;                                // [R24]
                settle_d  = 7'(BCK_SETTLE);
            end
        end else if (!src_locked) begin
            rdy_d = 1'b0;                                          // [R19]
        end else if (!rdy_q) begin
            if (settle_q == '0)
                rdy_d = 1'b1;                                      // [R16]
            else if (sel_tick)
                settle_d = settle_q - 1'b1;
        end
    end

    assign bus_src_active = act_src_q;                             // [R13]
    assign bus_pre_active = act_pre_q;                             // [R14]
    assign core_bus_ratio = brat_q;                                // [R15]
    assign osc_enable     = osc_en_q;

    // ----------------------------------------------------------------
    // status and interrupt line
    // ----------------------------------------------------------------
    assign status[ST_OSC]     = osc_ok_q;
    assign status[ST_LOCK_A]  = lock_q[0];
    assign status[ST_LOCK_B]  = lock_q[1];
    assign status[ST_BUS_RDY] = rdy_q;
    assign clock_irq = |(status & irq_en_q);                       // [R2]

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_pend_q   <= 1'b0;
            addr_q      <= '0;
            rdata_q     <= '0;
            osc_en_q    <= 1'b0;
            osc_cnt_q   <= '0;
            syn_a_q     <= SYN_CFG_W'(SYN_RESET);
            syn_b_q     <= SYN_CFG_W'(SYN_RESET);
            bsrc_q      <= SRC_SLOW;
            bpre_q      <= '0;
            brat_q      <= '0;
            irq_en_q    <= '0;
            cp_q        <= '0;
            osc_tmr_q   <= '0;
            osc_ok_q    <= 1'b0;
            win_q       <= '0;
            mcnt_q      <= '0;
            frq_q       <= '0;
            frq_valid_q <= 1'b0;
            lock_q      <= '0;
            act_src_q   <= SRC_SLOW;
            act_pre_q   <= '0;
            settle_q    <= '0;
            rdy_q       <= 1'b1;
        end else begin
            wr_pend_q   <= wr_pend_d;
            addr_q      <= addr_d;
            rdata_q     <= rdata_d;
            osc_en_q    <= osc_en_d;
            osc_cnt_q   <= osc_cnt_d;
            syn_a_q     <= syn_a_d;
            syn_b_q     <= syn_b_d;
            bsrc_q      <= bsrc_d;
            bpre_q      <= bpre_d;
            brat_q      <= brat_d;
            irq_en_q    <= irq_en_d;
            cp_q        <= cp_d;
            osc_tmr_q   <= osc_tmr_d;
            osc_ok_q    <= osc_ok_d;
            win_q       <= win_d;
            mcnt_q      <= mcnt_d;
            frq_q       <= frq_d;
            frq_valid_q <= frq_valid_d;
            lock_q      <= lock_d;
            act_src_q   <= act_src_d;
            act_pre_q   <= act_pre_d;
            settle_q    <= settle_d;
            rdy_q       <= rdy_d;
        end
    end
endmodule

// [dv/csp_clock_setup_monitor.sv]
// port-level assertion checker for the clock setup block
`timescale 1ns/1ps
module csp_clock_setup_monitor
    import csp_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 rstn,
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic [31:0]          hwdata,
    input wire logic                 hready,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    input wire logic                 osc_enable,
    input wire logic [SYN_DIV_W-1:0] syn_a_div,
    input wire logic [SYN_MUL_W-1:0] syn_a_mul,
    input wire logic                 syn_a_on,
    input wire logic [SYN_DIV_W-1:0] syn_b_div,
    input wire logic [SYN_MUL_W-1:0] syn_b_mul,
    input wire logic                 syn_b_on,
    input wire logic [SYN_USB_W-1:0] usb_div_log2,
    input wire logic [BCK_RAT_W-1:0] core_bus_ratio
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ---------------------------------------------------------
    // data phase tracking
    // ---------------------------------------------------------
    logic       dp_wr_q;
    logic [7:0] dp_off_q;
    always_ff @(posedge clk) begin
        dp_wr_q  <= rstn && hsel && hready && hwrite
                    && htrans == HTRANS_NONSEQ;
        dp_off_q <= haddr[7:0];
    end
    // ---------------------------------------------------------
    // properties
    // ---------------------------------------------------------
    hready_one_a: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or flagged an error");
    a_on_flag_a: assert property (syn_a_on == (syn_a_mul != 0 && syn_a_div != 0))
        else $error("synth A enable does not follow its fields");
    b_on_flag_a: assert property (syn_b_on == (syn_b_mul != 0 && syn_b_div != 0))
        else $error("synth B enable does not follow its fields");
    usb_div_range_a: assert property (usb_div_log2 != 2'h3)
        else $error("usb divide outside 1, 2, 4");
    ratio_range_a: assert property (core_bus_ratio != 2'h3)
        else $error("core ratio outside 1, 2, 4");
    a_write_apply_a: assert property (dp_wr_q && dp_off_q == OFF_SYN_A |=>
        syn_a_div == $past(hwdata[7:0]) && syn_a_mul == $past(hwdata[26:16]))
        else $error("synth A fields not taken together");
    b_write_apply_a: assert property (dp_wr_q && dp_off_q == OFF_SYN_B |=>
        syn_b_div == $past(hwdata[7:0]) && usb_div_log2 == $past(hwdata[29:28]))
        else $error("synth B fields not taken together");
    osc_write_apply_a: assert property (dp_wr_q && dp_off_q == OFF_OSC_CTRL
        |=> osc_enable == $past(hwdata[0]))
        else $error("oscillator enable not applied");
    ratio_write_a: assert property (dp_wr_q && dp_off_q == OFF_BUS_CLK
        && hwdata[9:8] != 2'h3 |=> core_bus_ratio == $past(hwdata[9:8]))
        else $error("core ratio not applied");
endmodule
bind csp_clock_setup csp_clock_setup_monitor u_mon (.clk, .rstn, .hsel,
    .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
    .osc_enable, .syn_a_div, .syn_a_mul, .syn_a_on, .syn_b_div, .syn_b_mul,
    .syn_b_on, .usb_div_log2, .core_bus_ratio);

// [dv/csp_clock_setup_tb.sv]
// self-checking register-level testbench for the clock setup block
`timescale 1ns/1ps
module csp_clock_setup_tb;
    import csp_pkg::*;
    logic clk, rstn, hsel, hwrite, hready, slow_tick, main_tick;
    logic syn_a_tick, syn_b_tick, hreadyout, hresp, osc_enable, clock_irq;
    logic syn_a_on, syn_b_on;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, syn_a_range, syn_b_range, usb_div_log2;
    logic [1:0]  bus_src_active, core_bus_ratio;
    logic [2:0]  hsize, bus_pre_active;
    logic [7:0]  syn_a_div, syn_b_div;
    logic [10:0] syn_a_mul, syn_b_mul;
    int          err_total, checks_done, cyc;
    logic [7:0]  offs [7] = '{OFF_OSC_CTRL, OFF_OSC_FREQ, OFF_SYN_A,
                             OFF_SYN_B, OFF_BUS_CLK, OFF_IRQ_EN, OFF_CP_CFG};
    logic [31:0] rstv [7] = '{0, 0, SYN_RESET, SYN_RESET, 0, 0, 0};
    csp_clock_setup DUT (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .slow_tick,
        .main_tick, .syn_a_tick, .syn_b_tick, .osc_enable, .syn_a_div,
        .syn_a_mul, .syn_a_range, .syn_a_on, .syn_b_div, .syn_b_mul,
        .syn_b_range, .syn_b_on, .usb_div_log2, .bus_src_active,
        .bus_pre_active, .core_bus_ratio, .clock_irq);
    assign hready = hreadyout;
    // ---------------------------------------------------------
    // clock, ticks, watchdog
    // ---------------------------------------------------------
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    // slow tick every 8 cycles: 64 main ticks fit in sixteen slow ticks
    always @(posedge clk) begin
        cyc        <= cyc + 1;
        slow_tick  <= (cyc % 8 == 7);
        main_tick  <= cyc[0];
        syn_a_tick <= (cyc % 3 == 0);
        syn_b_tick <= (cyc % 5 == 0);
    end
    initial begin
        #(25 * 30000);
        err_total++;
        final_report();
    end
    // ---------------------------------------------------------
    // tasks
    // ---------------------------------------------------------
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic ahb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        hsel   <= 1;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        #1; // let outputs settle past the edge
    endtask
    task automatic rchk(string n, logic [7:0] a, logic [31:0] m,
                        logic [31:0] e);
        ahb(0, a, 0);
        check(n, rd & m, e);
    endtask
    task automatic wait_slow(int n);
        repeat (n) do @(posedge clk); while (slow_tick !== 1'b1);
    endtask
    task automatic final_report();
        if (err_total == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ---------------------------------------------------------
    // tests
    // ---------------------------------------------------------
    initial begin
        {rstn, hsel, hwrite, cyc, err_total, checks_done} = 0;
        {slow_tick, main_tick, syn_a_tick, syn_b_tick} = 0;
        {haddr, hwdata, htrans} = 0;
        hsize = 3'h2;
        repeat (10) @(posedge clk);
        rstn <= 1;
        for (int i = 0; i < 7; i++) rchk("reset", offs[i], '1, rstv[i]);
        rchk("status", OFF_STATUS, 32'hF, 32'h0000_0008);
        rchk("unmapped", 8'h40, '1, 0);
        // oscillator start-up 8 x 2 slow ticks
        ahb(1, OFF_OSC_CTRL, 32'h0000_0201);
        check("osc_enable", osc_enable, 1);
        wait_slow(15);
        rchk("osc early", OFF_STATUS, 32'h1, 0);
        wait_slow(3);
        rchk("osc stable", OFF_STATUS, 32'h1, 1);
        wait_slow(18);
        rchk("freq valid", OFF_OSC_FREQ, 32'h1_0000, 32'h1_0000);
        check("freq count", (rd[15:0] >= 63 && rd[15:0] <= 65), 1);
        // synth A: lock count 6
        ahb(1, OFF_CP_CFG, 32'h0000_0001);
        ahb(1, OFF_SYN_A, 32'h2003_0605);
        rchk("lock A clear", OFF_STATUS, 32'h2, 0);
        check("a fields", {syn_a_div, syn_a_mul, syn_a_range, syn_a_on},
              {8'h5, 11'h3, 2'h0, 1'b1});
        wait_slow(4);
        rchk("lock A early", OFF_STATUS, 32'h2, 0);
        wait_slow(3);
        rchk("lock A", OFF_STATUS, 32'h2, 32'h2);
        ahb(1, OFF_IRQ_EN, 32'h0000_0002);
        check("irq on", clock_irq, 1);
        ahb(1, OFF_IRQ_EN, 32'h0000_0000);
        check("irq off", clock_irq, 0);
        // synth B with range 2, usb divide 2, lock count 8
        ahb(1, OFF_CP_CFG, 32'h0000_0003);
        ahb(1, OFF_SYN_B, 32'h1004_8805);
        check("b fields",
              {syn_b_div, syn_b_mul, syn_b_range, usb_div_log2, syn_b_on},
              {8'h5, 11'h4, 2'h2, 2'h1, 1'b1});
        wait_slow(10);
        rchk("lock B", OFF_STATUS, 32'h4, 32'h4);
        // master clock: source first to main, then prescaler
        ahb(1, OFF_BUS_CLK, 32'h0000_0001);
        rchk("rdy clear", OFF_STATUS, 32'h8, 0);
        wait_slow(20);
        check("src main", bus_src_active, SRC_MAIN);
        rchk("rdy main", OFF_STATUS, 32'h8, 32'h8);
        ahb(1, OFF_BUS_CLK, 32'h0000_0011);
        rchk("rdy pre", OFF_STATUS, 32'h8, 0);
        wait_slow(20);
        check("pre", bus_pre_active, 3'h4);
        rchk("rdy pre set", OFF_STATUS, 32'h8, 32'h8);
        ahb(1, OFF_BUS_CLK, 32'h0000_0012);
        wait_slow(30);
        check("src A", bus_src_active, SRC_SYNA);
        // reprogram the feeding synth: fallback to slow until relock
        ahb(1, OFF_SYN_A, 32'h2003_0605);
        rchk("rdy unlock", OFF_STATUS, 32'hA, 0);
        wait_slow(2);
        check("fallback", bus_src_active, SRC_SLOW);
        wait_slow(40);
        rchk("rdy relock", OFF_STATUS, 32'hA, 32'hA);
        check("src A back", bus_src_active, SRC_SYNA);
        ahb(1, OFF_BUS_CLK, 32'h0000_0212);
        check("ratio", core_bus_ratio, 2'h2);
        rchk("rdy ratio", OFF_STATUS, 32'h8, 32'h8);
        ahb(1, OFF_SYN_A, 32'h2003_0600);
        check("div off", syn_a_on, 0);
        final_report();
    end
endmodule
